// File: verilog/pcc_top.sv
/*
  Position compare channels: parameter port, settings registers, channel 1
  comparator and status bit, channel 2 criterion setting.
  Assumes a word-addressed parameter port with one-cycle read and write
  strobes, and a position sample of encoder 1 marked by a one-cycle valid.
*/
`timescale 1ns/1ps
module pcc_top
  import pcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  output logic [15:0] param_rdata_o,
  output logic param_ack_o,
  output logic param_err_o,
  input wire logic signed [31:0] enc1_pos_i,
  input wire logic enc1_pos_valid_i,
  output logic ch1_status_o,
  output logic [2:0] ch2_criterion_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  logic [1:0] ch1_run_q;
  logic [1:0] ch1_run_d;
  logic [2:0] ch1_crit_q;
  logic [2:0] ch1_crit_d;
  logic [2:0] ch2_crit_q;
  logic [2:0] ch2_crit_d;
  logic [15:0] ch1_src_q;
  logic [15:0] ch1_src_d;
  logic [31:0] ch1_val_a_q;
  logic [31:0] ch1_val_a_d;
  logic [31:0] ch1_val_b_q;
  logic [31:0] ch1_val_b_d;

  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic ack_q;
  logic err_q;
  logic err_d;
  logic [2:0] ch2_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic hit_run;
  logic hit_crit1;
  logic hit_crit2;
  logic hit_src;
  logic hit_a_hi;
  logic hit_a_lo;
  logic hit_b_hi;
  logic hit_b_lo;
  logic hit_any;
  logic access;
  logic wr_en;

  assign hit_run = (param_addr_i == PCC_ADDR_CH1_RUN);
  assign hit_crit1 = (param_addr_i == PCC_ADDR_CH1_CRIT);
  assign hit_crit2 = (param_addr_i == PCC_ADDR_CH2_CRIT);
  assign hit_src = (param_addr_i == PCC_ADDR_CH1_SRC);
  assign hit_a_hi = (param_addr_i == PCC_ADDR_CH1_A_HI);
  assign hit_a_lo = (param_addr_i == PCC_ADDR_CH1_A_LO);
  assign hit_b_hi = (param_addr_i == PCC_ADDR_CH1_B_HI);
  assign hit_b_lo = (param_addr_i == PCC_ADDR_CH1_B_LO);
  assign hit_any = hit_run | hit_crit1 | hit_crit2 | hit_src | hit_a_hi | hit_a_lo
                 | hit_b_hi | hit_b_lo;
  // A write wins when both strobes are raised together
  assign access = param_wr_i | param_rd_i;
  assign wr_en = param_wr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Write value checks: out-of-range codes are refused and flagged
  logic crit_ok;
  logic run_ok;
  logic src_ok;
  logic wr_refused;

  assign crit_ok = (param_wdata_i <= PCC_CRIT_MAX);
  assign run_ok = (param_wdata_i <= PCC_RUN_MAX);
  assign src_ok = (param_wdata_i == PCC_SRC_ENC1);
  assign wr_refused = (hit_run && !run_ok) || (hit_crit1 && !crit_ok)
                    || (hit_crit2 && !crit_ok) || (hit_src && !src_ok);

  // settings load on the write edge
  assign ch1_run_d = (wr_en && hit_run && run_ok) ? param_wdata_i[1:0] : ch1_run_q;
  assign ch1_crit_d = (wr_en && hit_crit1 && crit_ok) ? param_wdata_i[2:0] : ch1_crit_q;
  assign ch2_crit_d = (wr_en && hit_crit2 && crit_ok) ? param_wdata_i[2:0] : ch2_crit_q;
  assign ch1_src_d = (wr_en && hit_src && src_ok) ? param_wdata_i : ch1_src_q;

  // each word of A and B is written on its own
  assign ch1_val_a_d = (wr_en && hit_a_hi) ? {param_wdata_i, ch1_val_a_q[15:0]} :
                       (wr_en && hit_a_lo) ? {ch1_val_a_q[31:16], param_wdata_i} :
                       ch1_val_a_q;
  assign ch1_val_b_d = (wr_en && hit_b_hi) ? {param_wdata_i, ch1_val_b_q[15:0]} :
                       (wr_en && hit_b_lo) ? {ch1_val_b_q[31:16], param_wdata_i} :
                       ch1_val_b_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data and answer flags
  always_comb begin
    rdata_d = 16'h0000;
    if (!param_rd_i || wr_en) begin
      rdata_d = 16'h0000;
    end else if (hit_run) begin
      rdata_d = {14'h0000, ch1_run_q};
    end else if (hit_crit1) begin
      rdata_d = {13'h0000, ch1_crit_q};
    end else if (hit_crit2) begin
      rdata_d = {13'h0000, ch2_crit_q};
    end else if (hit_src) begin
      rdata_d = ch1_src_q;
    end else if (hit_a_hi) begin
      rdata_d = ch1_val_a_q[31:16];
    end else if (hit_a_lo) begin
      rdata_d = ch1_val_a_q[15:0];
    end else if (hit_b_hi) begin
      rdata_d = ch1_val_b_q[31:16];
    end else if (hit_b_lo) begin
      rdata_d = ch1_val_b_q[15:0];
    end
  end

  assign err_d = access && (!hit_any || (wr_en && wr_refused));

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ch1_run_q <= PCC_RST_RUN;
      ch1_crit_q <= PCC_RST_CRIT;
      ch2_crit_q <= PCC_RST_CRIT;
      ch1_src_q <= PCC_RST_SRC;
      ch1_val_a_q <= PCC_RST_VAL;
      ch1_val_b_q <= PCC_RST_VAL;
    end else if (ce_i) begin
      ch1_run_q <= ch1_run_d;
      ch1_crit_q <= ch1_crit_d;
      ch2_crit_q <= ch2_crit_d;
      ch1_src_q <= ch1_src_d;
      ch1_val_a_q <= ch1_val_a_d;
      ch1_val_b_q <= ch1_val_b_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
      ack_q <= access;
      err_q <= err_d;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ch2_out_q <= PCC_RST_CRIT;
    end else if (ce_i) begin
      ch2_out_q <= ch2_crit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel 1 comparator and status
  logic ch1_hit;
  logic ch1_sample;

  assign ch1_sample = enc1_pos_valid_i && (ch1_src_q == PCC_SRC_ENC1);

  pcc_compare u_cmp1 (
    .pos_i(enc1_pos_i),
    .val_a_i(ch1_val_a_q),
    .val_b_i(ch1_val_b_q),
    .crit_i(ch1_crit_q),
    .hit_o(ch1_hit)
  );

  pcc_status u_st1 (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .run_i(ch1_run_q),
    .sample_i(ch1_sample),
    .hit_i(ch1_hit),
    .status_o(ch1_status_o)
  );

  assign param_rdata_o = rdata_q;
  assign param_ack_o = ack_q;
  assign param_err_o = err_q;
  assign ch2_criterion_o = ch2_out_q;

endmodule

// File: verilog/pcc_pkg.sv
/*
  Shared constants for the position compare channels: parameter addresses,
  field widths, reset values and the criterion and run-control codes.
  Assumes a 16-bit word-addressed parameter port, one address per 16-bit word.
*/
// What this block does
// - Code 0: status true when position is at least value A.
// - Code 1: status true when position is at most value A.
// - Code 2: status true when position is between A and B, limits inside.
// - Code 3: status true when position is outside A to B, limits inside.
// - Code 4: status true when position is within the A-B span, limits included.
// - Code 5: status true when position is outside the A-B span, limits inside.
// - Source selector accepts only code 0, encoder 1 position; default 0.
// - Run code 0: comparing stops, status keeps its last value.
// - Run code 1: channel active, status follows the selected criterion.
// - Run code 2: channel inactive, status forced to zero.
// - Run code 3: channel inactive, status forced to one.
// - Two signed 32-bit comparison values A and B for channel one only, reset zero.
// - Criterion, source and run writes take effect at once.
// - Channel two has its own criterion setting, codes 0 to 5, default 0.
package pcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PCC_AW = 16;
  localparam int PCC_DW = 16;
  localparam int PCC_POSW = 32;
  localparam int PCC_CRITW = 3;
  localparam int PCC_RUNW = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter addresses; 32-bit values use addr (high word) and addr+1 (low)
  localparam logic [15:0] PCC_ADDR_CH1_RUN = 16'h0B04;
  localparam logic [15:0] PCC_ADDR_CH1_CRIT = 16'h0B08;
  localparam logic [15:0] PCC_ADDR_CH2_CRIT = 16'h0B0A;
  localparam logic [15:0] PCC_ADDR_CH1_SRC = 16'h0B0C;
  localparam logic [15:0] PCC_ADDR_CH1_A_HI = 16'h0B10;
  localparam logic [15:0] PCC_ADDR_CH1_A_LO = 16'h0B11;
  localparam logic [15:0] PCC_ADDR_CH1_B_HI = 16'h0B12;
  localparam logic [15:0] PCC_ADDR_CH1_B_LO = 16'h0B13;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [1:0] PCC_RST_RUN = 2'h0;
  localparam logic [2:0] PCC_RST_CRIT = 3'h0;
  localparam logic [15:0] PCC_RST_SRC = 16'h0000;
  localparam logic [31:0] PCC_RST_VAL = 32'h00000000;
  localparam logic PCC_RST_STATUS = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [2:0] PCC_CRIT_GE_A = 3'h0;
  localparam logic [2:0] PCC_CRIT_LE_A = 3'h1;
  localparam logic [2:0] PCC_CRIT_IN_BASIC = 3'h2;
  localparam logic [2:0] PCC_CRIT_OUT_BASIC = 3'h3;
  localparam logic [2:0] PCC_CRIT_IN_EXT = 3'h4;
  localparam logic [2:0] PCC_CRIT_OUT_EXT = 3'h5;
  localparam logic [15:0] PCC_CRIT_MAX = 16'h0005;

  localparam logic [1:0] PCC_RUN_HOLD = 2'h0;
  localparam logic [1:0] PCC_RUN_ON = 2'h1;
  localparam logic [1:0] PCC_RUN_FORCE0 = 2'h2;
  localparam logic [1:0] PCC_RUN_FORCE1 = 2'h3;
  localparam logic [15:0] PCC_RUN_MAX = 16'h0003;

  localparam logic [15:0] PCC_SRC_ENC1 = 16'h0000;

  typedef enum logic [1:0] {
    PCC_ST_HOLD,
    PCC_ST_ON,
    PCC_ST_FORCE0,
    PCC_ST_FORCE1
  } pcc_run_t;

  function automatic pcc_run_t pcc_run_decode(input logic [1:0] code);
    pcc_run_t r;
    r = PCC_ST_HOLD;
    if (code == PCC_RUN_ON) begin
      r = PCC_ST_ON;
    end else if (code == PCC_RUN_FORCE0) begin
      r = PCC_ST_FORCE0;
    end else if (code == PCC_RUN_FORCE1) begin
      r = PCC_ST_FORCE1;
    end
    return r;
  endfunction

endpackage

// File: verilog/pcc_compare.sv
/*
  Combinational criterion evaluation for one compare channel.
  Assumes position, A and B are signed two's complement 32-bit values.
*/
`timescale 1ns/1ps
module pcc_compare
  import pcc_pkg::*;
(
  input wire logic signed [31:0] pos_i,
  input wire logic signed [31:0] val_a_i,
  input wire logic signed [31:0] val_b_i,
  input wire logic [2:0] crit_i,
  output logic hit_o
);

  logic signed [31:0] lo_ext;
  logic signed [31:0] hi_ext;
  logic in_basic;
  logic in_ext;

  assign lo_ext = (val_a_i <= val_b_i) ? val_a_i : val_b_i;
  assign hi_ext = (val_a_i <= val_b_i) ? val_b_i : val_a_i;
  assign in_basic = (pos_i >= val_a_i) && (pos_i <= val_b_i);
  assign in_ext = (pos_i >= lo_ext) && (pos_i <= hi_ext);

  always_comb begin
    hit_o = 1'b0;
    case (crit_i)
      PCC_CRIT_GE_A: hit_o = (pos_i >= val_a_i);
      PCC_CRIT_LE_A: hit_o = (pos_i <= val_a_i);
      PCC_CRIT_IN_BASIC: hit_o = in_basic;
      PCC_CRIT_OUT_BASIC: hit_o = (pos_i < val_a_i) || (pos_i > val_b_i);
      PCC_CRIT_IN_EXT: hit_o = in_ext;
      PCC_CRIT_OUT_EXT: hit_o = !in_ext;
      default: hit_o = 1'b0;
    endcase
  end

endmodule

// File: verilog/pcc_status.sv
/*
  Status bit of one compare channel under the run control.
  Assumes sample_i is a one-cycle strobe marking a new position sample.
*/
`timescale 1ns/1ps
module pcc_status
  import pcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [1:0] run_i,
  input wire logic sample_i,
  input wire logic hit_i,
  output logic status_o
);

  pcc_run_t run_state;
  logic status_d;
  logic status_q;

  assign run_state = pcc_run_decode(run_i);

  always_comb begin
    status_d = status_q;
    case (run_state)
      PCC_ST_HOLD: status_d = status_q;
      PCC_ST_ON: status_d = sample_i ? hit_i : status_q;
      PCC_ST_FORCE0: status_d = 1'b0;
      PCC_ST_FORCE1: status_d = 1'b1;
      default: status_d = status_q;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      status_q <= PCC_RST_STATUS;
    end else if (ce_i) begin
      status_q <= status_d;
    end
  end

  assign status_o = status_q;

endmodule

// File: verification/pcc_top_monitor.sv
/* Port checker for pcc_top, bound to every instance.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/1ps
module pcc_top_monitor
  import pcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_rdata_o,
  input wire logic param_ack_o,
  input wire logic param_err_o,
  input wire logic signed [31:0] enc1_pos_i,
  input wire logic enc1_pos_valid_i,
  input wire logic ch1_status_o,
  input wire logic [2:0] ch2_criterion_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire acc_w = ce_i && (param_wr_i || param_rd_i);
  wire wr_w = ce_i && param_wr_i;
  wire run_wr = wr_w && param_addr_i == PCC_ADDR_CH1_RUN;
  wire mapped = param_addr_i inside {[16'h0B10:16'h0B13], 16'h0B04, 16'h0B08, 16'h0B0A, 16'h0B0C};
  logic [1:0] run_q;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      run_q <= 2'h0;
    end else if (run_wr && param_wdata_i <= PCC_RUN_MAX) begin
      run_q <= param_wdata_i[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_after_strobe: assert property (acc_w |=> param_ack_o)
    else $error("no ack after strobe");
  chk_ack_no_strobe: assert property (ce_i && !acc_w |=> !param_ack_o)
    else $error("ack without strobe");
  chk_unmapped_err: assert property (
    acc_w && !mapped |=> param_err_o && param_rdata_o == 16'h0000)
    else $error("unmapped access not refused");
  chk_crit_range: assert property (
    wr_w && param_addr_i == PCC_ADDR_CH1_CRIT && param_wdata_i > PCC_CRIT_MAX |=> param_err_o)
    else $error("criterion out of range accepted");
  chk_src_only_zero: assert property (
    wr_w && param_addr_i == PCC_ADDR_CH1_SRC && param_wdata_i != 16'h0000 |=> param_err_o)
    else $error("nonzero source accepted");
  chk_ch2_crit_load: assert property (
    wr_w && param_addr_i == PCC_ADDR_CH2_CRIT && param_wdata_i <= PCC_CRIT_MAX
    |=> ch2_criterion_o == $past(param_wdata_i[2:0]))
    else $error("channel two criterion not loaded");
  chk_force_zero: assert property (
    run_wr && param_wdata_i == 16'h0002 ##1 ce_i |=> !ch1_status_o)
    else $error("status not forced low");
  chk_force_one: assert property (
    run_wr && param_wdata_i == 16'h0003 ##1 ce_i |=> ch1_status_o)
    else $error("status not forced high");
  chk_hold_status: assert property (run_q == PCC_RUN_HOLD |=> $stable(ch1_status_o))
    else $error("status moved while stopped");
endmodule
bind pcc_top pcc_top_monitor i_mon (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .param_addr_i(param_addr_i), .param_wdata_i(param_wdata_i), .param_wr_i(param_wr_i),
  .param_rd_i(param_rd_i), .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o),
  .param_err_o(param_err_o), .enc1_pos_i(enc1_pos_i), .enc1_pos_valid_i(enc1_pos_valid_i),
  .ch1_status_o(ch1_status_o), .ch2_criterion_o(ch2_criterion_o));

// File: verification/pcc_enc_model.sv
/* Encoder feedback model: presents one position sample per request.
   Assumes requests come from the bench; slow_i adds three cycles of delay. */
`timescale 1ns/1ps
module pcc_enc_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic slow_i,
  input wire logic signed [31:0] tgt_i,
  output logic signed [31:0] pos_o,
  output logic valid_o
);
  logic pend_q;
  logic [1:0] cnt_q;
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pend_q <= 1'b0;
      cnt_q <= 2'h0;
      valid_o <= 1'b0;
      pos_o <= 32'h00000000;
    end else begin
      valid_o <= 1'b0;
      // Position bus is meaningless between samples, so keep it moving
      pos_o <= ~pos_o;
      if (req_i) begin
        pend_q <= 1'b1;
        cnt_q <= slow_i ? 2'h3 : 2'h0;
      end else if (pend_q && cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        valid_o <= 1'b1;
        pos_o <= tgt_i;
      end
    end
  end
endmodule

// File: verification/tb.sv
/* Self-checking bench for pcc_top with a reference model of the channel.
   Assumes the encoder model supplies samples on request. */
`timescale 1ns/1ps
module tb
  import pcc_pkg::*;
;
  logic core_clk_i = 0, resetn_i = 0, ce_i = 1, param_wr_i = 0, param_rd_i = 0;
  logic req = 0, slow = 0, param_ack_o, param_err_o, enc1_pos_valid_i, ch1_status_o;
  logic [15:0] param_addr_i = 0, param_wdata_i = 0, param_rdata_o;
  logic [2:0] ch2_criterion_o;
  logic signed [31:0] enc1_pos_i, tgt = 0;
  logic [31:0] seed = 32'h0000003A;
  logic [15:0] adr [8] = '{PCC_ADDR_CH1_RUN, PCC_ADDR_CH1_CRIT, PCC_ADDR_CH2_CRIT,
    PCC_ADDR_CH1_SRC, PCC_ADDR_CH1_A_HI, PCC_ADDR_CH1_A_LO, PCC_ADDR_CH1_B_HI, PCC_ADDR_CH1_B_LO};
  int n_fail = 0, n_checks = 0, a, b, crit = 0, run = 0, st = 0, p[5];
  pcc_top i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .param_addr_i(param_addr_i), .param_wdata_i(param_wdata_i), .param_wr_i(param_wr_i),
    .param_rd_i(param_rd_i), .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o),
    .param_err_o(param_err_o), .enc1_pos_i(enc1_pos_i), .enc1_pos_valid_i(enc1_pos_valid_i),
    .ch1_status_o(ch1_status_o), .ch2_criterion_o(ch2_criterion_o));
  pcc_enc_model i_enc (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(req),
    .slow_i(slow), .tgt_i(tgt), .pos_o(enc1_pos_i), .valid_o(enc1_pos_valid_i));
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int hit(input int c, input int x);
    int lo, hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    case (c)
      0: return x >= a;
      1: return x <= a;
      2: return a <= x && x <= b;
      3: return x < a || x > b;
      4: return lo <= x && x <= hi;
      default: return x < lo || x > hi;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic [15:0] ad, input logic [15:0] d, input bit w, input bit e,
    input logic [15:0] exp);
    int k;
    @(posedge core_clk_i);
    param_addr_i <= ad;
    param_wdata_i <= d;
    param_wr_i <= w;
    param_rd_i <= !w;
    @(posedge core_clk_i);
    param_wr_i <= 1'b0;
    param_rd_i <= 1'b0;
    #1;
    for (k = 0; k < 4 && param_ack_o !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (k == 4) begin
      n_fail++;
      summarize();
    end
    chk(param_err_o, e);
    chk(param_rdata_o, w ? 16'h0000 : exp);
  endtask
  task samp(input int x);
    int k;
    @(posedge core_clk_i);
    tgt <= x;
    req <= 1'b1;
    @(posedge core_clk_i);
    req <= 1'b0;
    for (k = 0; k < 8 && enc1_pos_valid_i !== 1'b1; k++) begin
      @(posedge core_clk_i);
    end
    if (k == 8) begin
      n_fail++;
      summarize();
    end
    if (run == 1) begin
      st = hit(crit, x);
    end
    #1;
    chk(ch1_status_o, st);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    foreach (adr[i]) acc(adr[i], 16'h0000, 0, 0, 16'h0000);
    acc(16'h0B06, 16'h0000, 0, 1, 16'h0000);
    acc(16'h0B07, 16'h1234, 1, 1, 16'h0000);
    acc(PCC_ADDR_CH1_CRIT, 16'h0006, 1, 1, 16'h0000);
    acc(PCC_ADDR_CH1_RUN, 16'h0004, 1, 1, 16'h0000);
    acc(PCC_ADDR_CH1_SRC, 16'h0001, 1, 1, 16'h0000);
    acc(PCC_ADDR_CH1_SRC, 16'h0000, 1, 0, 16'h0000);
    for (int c = 0; c < 6; c++) begin
      acc(PCC_ADDR_CH2_CRIT, c, 1, 0, 16'h0000);
      chk(ch2_criterion_o, c);
      acc(PCC_ADDR_CH2_CRIT, 16'h0000, 0, 0, c);
    end
    acc(PCC_ADDR_CH1_RUN, PCC_RUN_ON, 1, 0, 16'h0000);
    run = 1;
    for (int n = 0; n < 3; n++) begin
      seed = lfsr(seed);
      a = $signed(seed[15:0]);
      seed = lfsr(seed);
      b = $signed(seed[15:0]);
      acc(PCC_ADDR_CH1_A_HI, a[31:16], 1, 0, 16'h0000);
      acc(PCC_ADDR_CH1_A_LO, a[15:0], 1, 0, 16'h0000);
      acc(PCC_ADDR_CH1_B_HI, b[31:16], 1, 0, 16'h0000);
      acc(PCC_ADDR_CH1_B_LO, b[15:0], 1, 0, 16'h0000);
      acc(PCC_ADDR_CH1_B_HI, 16'h0000, 0, 0, b[31:16]);
      p = '{a - 1, a, b, b + 1, (a + b) / 2};
      for (int c = 0; c < 6; c++) begin
        acc(PCC_ADDR_CH1_CRIT, c, 1, 0, 16'h0000);
        crit = c;
        foreach (p[i]) samp(p[i]);
      end
    end
    acc(PCC_ADDR_CH1_CRIT, PCC_CRIT_GE_A, 1, 0, 16'h0000);
    crit = 0;
    samp(a);
    slow <= 1'b1;
    acc(PCC_ADDR_CH1_RUN, PCC_RUN_HOLD, 1, 0, 16'h0000);
    run = 0;
    samp(a - 1);
    for (int f = 2; f < 4; f++) begin
      acc(PCC_ADDR_CH1_RUN, f, 1, 0, 16'h0000);
      run = f;
      st = f - 2;
      @(posedge core_clk_i);
      #1;
      chk(ch1_status_o, st);
      samp(a + f - 3);
    end
    // Clock enable low: a run write is ignored and the status is frozen
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    param_addr_i <= PCC_ADDR_CH1_RUN;
    param_wdata_i <= 16'h0002;
    param_wr_i <= 1'b1;
    @(posedge core_clk_i);
    param_wr_i <= 1'b0;
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    #1;
    chk(param_ack_o, 1'b0);
    chk(ch1_status_o, st);
    acc(PCC_ADDR_CH1_RUN, 16'h0000, 0, 0, 16'h0003);
    summarize();
  end
endmodule
